// file: rtl/srseq_defs.vh
`ifndef SRSEQ_DEFS_VH
`define SRSEQ_DEFS_VH

// ==========================================================
// register map (word index on the plain register port)
`define SRSEQ_ADDR_W        4
`define SRSEQ_REG_CTL       4'h0
`define SRSEQ_REG_STS       4'h1
`define SRSEQ_REG_MBSTS     4'h2
`define SRSEQ_REG_LINK      4'h3
`define SRSEQ_REG_EEP       4'h4
`define SRSEQ_REG_RST       4'h5
`define SRSEQ_REG_STICKY    4'h6

// ==========================================================
// control register fields
`define SRSEQ_CTL_SOFT_FUNDAMENTAL_RESET_BIT      0
`define SRSEQ_CTL_HRST      1
`define SRSEQ_CTL_HALT      2
`define SRSEQ_CTL_DHRSTSEI  3
`define SRSEQ_CTL_USBR      4
`define SRSEQ_CTL_DSBR      5

// ==========================================================
// management bus status fields
`define SRSEQ_MB_DONE       0
`define SRSEQ_MB_ERR        1
`define SRSEQ_MB_ERRC_LSB   4
`define SRSEQ_MB_ERRC_MSB   7

// ==========================================================
// switch mode codes
`define SRSEQ_MODE_NORM     3'h0
`define SRSEQ_MODE_EEP      3'h1
`define SRSEQ_MODE_LAT      3'h2
`define SRSEQ_MODE_EEPLAT   3'h3

// ==========================================================
// timing
`define SRSEQ_CLK_MHZ       250
`define SRSEQ_TRAIN_MS      20
`define SRSEQ_RETRY_MS      100
`define SRSEQ_CYC_PER_MS    (`SRSEQ_CLK_MHZ * 1000)
`define SRSEQ_MB_SLOW_KHZ   100
`define SRSEQ_MB_FAST_KHZ   400

`endif

// file: rtl/srseq_top.v
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ns
`include "srseq_defs.vh"
module srseq_top
#(
    parameter NPORT     = 5,
    parameter TRAIN_CYC = `SRSEQ_TRAIN_MS * `SRSEQ_CYC_PER_MS,
    parameter RETRY_CYC = `SRSEQ_RETRY_MS * `SRSEQ_CYC_PER_MS
)
(
    // clock and reset
    input  wire                     sys_clk,
    input  wire                     rst,
    // reset pin and straps
    input  wire                     fundamental_reset_pin_n,
    input  wire [2:0]               switch_op_mode_straps,
    input  wire                     reset_halt,
    input  wire                     master_mgmt_bus_slow_strap,
    input  wire [3:0]               slave_mgmt_bus_addr_straps,
    // register port
    input  wire [`SRSEQ_ADDR_W-1:0] reg_addr,
    input  wire [31:0]              reg_wdata,
    input  wire                     reg_wr,
    input  wire                     reg_rd,
    output reg  [31:0]              reg_rdata_ff,
    // hot reset sources
    input  wire                     hot_reset_req,
    // pll and bus handshakes
    input  wire                     pll_lock,
    input  wire                     slave_bus_ready,
    input  wire                     master_bus_ready,
    // eeprom loader
    input  wire                     eep_wr,
    input  wire [`SRSEQ_ADDR_W-1:0] eep_addr,
    input  wire [31:0]              eep_wdata,
    input  wire                     eep_done,
    input  wire                     eep_err,
    input  wire [3:0]               eep_err_code,
    // internal resets
    output reg                      pll_rst_ff,
    output reg                      train_en_ff,
    output reg                      stack_rst_ff,
    output reg                      quasi_rst_ff,
    output reg                      slave_bus_rst_ff,
    output reg                      master_bus_rst_ff,
    output reg                      master_bus_slow_ff,
    output reg  [3:0]               slave_bus_addr_ff,
    output reg                      eep_start_ff,
    output reg                      core_rst_ff,
    output reg                      us_hot_rst_ff,
    output reg  [NPORT-1:0]         ds_hot_rst_ff,
    output reg  [NPORT-1:0]         retrain_ff,
    output reg  [2:0]               op_mode_ff,
    output reg                      low_latency_ff,
    output reg                      train_late_ff,
    output reg                      retry_late_ff
);

// ==========================================================
// one-hot states
localparam S_WAIT  = 9'h001;
localparam S_PLL   = 9'h002;
localparam S_TRAIN = 9'h004;
localparam S_QUASI = 9'h008;
localparam S_SLAVE = 9'h010;
localparam S_MAST  = 9'h020;
localparam S_EEP   = 9'h040;
localparam S_HALT  = 9'h080;
localparam S_RUN   = 9'h100;

localparam CW = 32;

// ==========================================================
// pin synchronisers
reg  [1:0] pin_sync_ff;
reg  [1:0] halt_sync_ff;
reg  [1:0] slow_sync_ff;
reg  [5:0] mode_sync0_ff;
reg  [5:0] mode_sync1_ff;
reg        pin_n_q;
reg        halt_q;
reg        slow_q;
reg  [2:0] mode_q;
reg  [3:0] addr_q;

always @(posedge sys_clk or posedge rst)
begin
    if (rst)
    begin
        pin_sync_ff   <= 2'h0;
        halt_sync_ff  <= 2'h0;
        slow_sync_ff  <= 2'h0;
        mode_sync0_ff <= 6'h00;
        mode_sync1_ff <= 6'h00;
        addr_q        <= 4'h0;
    end
    else
    begin
        pin_sync_ff   <= {pin_sync_ff[0], fundamental_reset_pin_n};
        halt_sync_ff  <= {halt_sync_ff[0], reset_halt};
        slow_sync_ff  <= {slow_sync_ff[0], master_mgmt_bus_slow_strap};
        mode_sync0_ff <= {switch_op_mode_straps[2:0], 3'h0};
        mode_sync1_ff <= mode_sync0_ff;
        addr_q        <= slave_mgmt_bus_addr_straps;
    end
end

// second stages feed logic; address straps go through a two-stage pipe below
reg [3:0] addr_sync_ff;
always @(posedge sys_clk or posedge rst)
begin
    if (rst)
        addr_sync_ff <= 4'h0;
    else
        addr_sync_ff <= addr_q;
end

always @*
begin
    pin_n_q = pin_sync_ff[1];
    halt_q  = halt_sync_ff[1];
    slow_q  = slow_sync_ff[1];
    mode_q  = mode_sync1_ff[5:3];
end

// ==========================================================
// state and registers
reg  [8:0]       state_ff;
reg  [8:0]       nxt_state;
reg  [CW-1:0]    tmr_ff;
reg              pin_seen_ff;
reg              soft_pend_ff;
reg              halt_ctl_ff;
reg              halt_sts_ff;
reg              dhrstsei_ff;
reg              mb_done_ff;
reg              mb_err_ff;
reg  [3:0]       mb_errc_ff;
reg  [31:0]      sticky_ff;
reg  [NPORT-1:0] retrain_req;
reg              hot_q;
reg              hot_ff;
reg              eep_mode;
reg              fund;

wire sw_wr  = reg_wr;
wire ld_wr  = eep_wr && (state_ff == S_EEP);
wire ctl_w  = sw_wr && (reg_addr == `SRSEQ_REG_CTL);
wire ctl_lw = ld_wr && (eep_addr == `SRSEQ_REG_CTL);
wire [31:0] ctl_d = ctl_lw ? eep_wdata : reg_wdata;

always @*
begin
    eep_mode = (op_mode_ff == `SRSEQ_MODE_EEP) || (op_mode_ff == `SRSEQ_MODE_EEPLAT);
    fund     = !pin_n_q || soft_pend_ff;
    hot_q    = hot_reset_req || ((ctl_w || ctl_lw) && ctl_d[`SRSEQ_CTL_HRST]);
end

// low latency follows the mode register in the same cycle; reserved codes never select it
wire strap_take   = (state_ff == S_WAIT) && !fund && pin_seen_ff;
wire mode_lat_new = (mode_q == `SRSEQ_MODE_LAT) || (mode_q == `SRSEQ_MODE_EEPLAT);
wire mode_lat_cur = (op_mode_ff == `SRSEQ_MODE_LAT) || (op_mode_ff == `SRSEQ_MODE_EEPLAT);

// ==========================================================
// sequencer
always @*
begin
    nxt_state = state_ff;
    case (state_ff)
        S_WAIT:  if (!fund)                nxt_state = S_PLL;
        S_PLL:   if (pll_lock)             nxt_state = S_TRAIN;
        S_TRAIN:                           nxt_state = S_QUASI;
        S_QUASI:                           nxt_state = S_SLAVE;
        S_SLAVE: if (slave_bus_ready)      nxt_state = S_MAST;
        S_MAST:  if (master_bus_ready)
                     nxt_state = (eep_mode && !(hot_ff && dhrstsei_ff)) ? S_EEP : S_HALT;
        S_EEP:   if (eep_done || eep_err)  nxt_state = S_HALT;
        S_HALT:  if (!halt_ctl_ff)         nxt_state = S_RUN;
        S_RUN:                             nxt_state = S_RUN;
        default:                           nxt_state = S_WAIT;
    endcase
    if (fund)
        nxt_state = S_WAIT;
    else if (hot_q && state_ff == S_RUN)
        nxt_state = S_TRAIN;
end

always @(posedge sys_clk or posedge rst)
begin
    if (rst)
    begin
        state_ff     <= S_WAIT;
        tmr_ff       <= {CW{1'b0}};
        pin_seen_ff  <= 1'b1;
        soft_pend_ff <= 1'b0;
        op_mode_ff   <= `SRSEQ_MODE_NORM;
        halt_sts_ff  <= 1'b0;
        halt_ctl_ff  <= 1'b0;
        dhrstsei_ff  <= 1'b0;
        mb_done_ff   <= 1'b0;
        mb_err_ff    <= 1'b0;
        mb_errc_ff   <= 4'h0;
        sticky_ff    <= 32'h0000_0000;
        hot_ff       <= 1'b0;
        slave_bus_addr_ff  <= 4'h0;
        master_bus_slow_ff <= 1'b0;
        train_late_ff      <= 1'b0;
        retry_late_ff      <= 1'b0;
    end
    else
    begin
        state_ff <= nxt_state;
        // soft reset acts the cycle after the write, once the write has completed
        if (ctl_w && reg_wdata[`SRSEQ_CTL_SOFT_FUNDAMENTAL_RESET_BIT])
            soft_pend_ff <= 1'b1;
        else if (state_ff == S_WAIT)
            soft_pend_ff <= 1'b0;
        if (!pin_n_q)
            pin_seen_ff <= 1'b1;
        // bus status, sticky and dhrstsei are cleared in every cycle of S_WAIT, not only at its end
        if (state_ff == S_WAIT)
        begin
            sticky_ff   <= 32'h0000_0000;
            dhrstsei_ff <= 1'b0;
            mb_done_ff  <= 1'b0;
            mb_err_ff   <= 1'b0;
            mb_errc_ff  <= 4'h0;
        end
        if (state_ff == S_WAIT && !fund)
        begin
            tmr_ff <= {CW{1'b0}};
            hot_ff <= 1'b0;
            if (pin_seen_ff)
            begin
                op_mode_ff         <= mode_q;
                halt_sts_ff        <= halt_q;
                halt_ctl_ff        <= halt_q;
                master_bus_slow_ff <= slow_q;
                slave_bus_addr_ff  <= addr_sync_ff;
                pin_seen_ff        <= 1'b0;
            end
        end
        else if (state_ff != S_RUN && tmr_ff != {CW{1'b1}})
            tmr_ff <= tmr_ff + 1'b1;
        if (nxt_state == S_TRAIN && state_ff == S_RUN)
        begin
            hot_ff    <= 1'b1;                                   // sticky kept
            tmr_ff    <= {CW{1'b0}};
            mb_done_ff <= 1'b0;
        end
        // watchdog flags for the 20 ms and 100 ms windows
        if (state_ff == S_PLL && tmr_ff >= TRAIN_CYC)
            train_late_ff <= 1'b1;
        if ((state_ff == S_PLL || state_ff == S_TRAIN) && tmr_ff >= RETRY_CYC)
            retry_late_ff <= 1'b1;
        // control register: set by load error wins over software clear
        if (state_ff == S_EEP && eep_err)
            halt_ctl_ff <= 1'b1;
        else if (ctl_w || ctl_lw)
        begin
            halt_ctl_ff <= ctl_d[`SRSEQ_CTL_HALT];
            dhrstsei_ff <= ctl_d[`SRSEQ_CTL_DHRSTSEI];
        end
        if (state_ff == S_EEP && (eep_done || eep_err))
            mb_done_ff <= 1'b1;
        if (state_ff == S_EEP && eep_err)
        begin
            mb_err_ff  <= 1'b1;
            mb_errc_ff <= eep_err_code;
        end
        if ((sw_wr && reg_addr == `SRSEQ_REG_STICKY) ||
            (ld_wr && eep_addr == `SRSEQ_REG_STICKY))
            sticky_ff <= ld_wr ? eep_wdata : reg_wdata;
    end
end

// ==========================================================
// outputs from flip-flops
always @*
begin
    retrain_req = {NPORT{1'b0}};
    if (sw_wr && reg_addr == `SRSEQ_REG_LINK)
        retrain_req = reg_wdata[NPORT-1:0];
    if (ld_wr && eep_addr == `SRSEQ_REG_LINK)
        retrain_req = eep_wdata[NPORT-1:0];
end

wire ctl_any = ctl_w || ctl_lw;

always @(posedge sys_clk or posedge rst)
begin
    if (rst)
    begin
        pll_rst_ff        <= 1'b1;
        train_en_ff       <= 1'b0;
        stack_rst_ff      <= 1'b1;
        quasi_rst_ff      <= 1'b0;
        slave_bus_rst_ff  <= 1'b1;
        master_bus_rst_ff <= 1'b1;
        eep_start_ff      <= 1'b0;
        core_rst_ff       <= 1'b1;
        us_hot_rst_ff     <= 1'b0;
        ds_hot_rst_ff     <= {NPORT{1'b0}};
        retrain_ff        <= {NPORT{1'b0}};
        low_latency_ff    <= 1'b0;
    end
    else
    begin
        pll_rst_ff        <= (nxt_state == S_WAIT);
        train_en_ff       <= !(nxt_state == S_WAIT || nxt_state == S_PLL);
        // test modes (reserved codes) keep the stacks in reset
        stack_rst_ff      <= (nxt_state == S_WAIT || nxt_state == S_PLL ||
                              nxt_state == S_TRAIN || op_mode_ff[2]);
        quasi_rst_ff      <= !(nxt_state == S_WAIT || nxt_state == S_PLL ||
                               nxt_state == S_TRAIN || nxt_state == S_RUN ||
                               op_mode_ff[2]);
        slave_bus_rst_ff  <= (nxt_state == S_WAIT || nxt_state == S_PLL ||
                              nxt_state == S_TRAIN || nxt_state == S_QUASI);
        master_bus_rst_ff <= !(nxt_state == S_MAST || nxt_state == S_EEP ||
                               nxt_state == S_HALT || nxt_state == S_RUN);
        eep_start_ff      <= (nxt_state == S_EEP) && (state_ff != S_EEP);
        core_rst_ff       <= (nxt_state != S_RUN);
        us_hot_rst_ff     <= ctl_any && ctl_d[`SRSEQ_CTL_USBR];
        ds_hot_rst_ff     <= (ctl_any && ctl_d[`SRSEQ_CTL_DSBR]) ?
                             ctl_d[8+NPORT-1:8] : {NPORT{1'b0}};
        retrain_ff        <= retrain_req;
        low_latency_ff    <= strap_take ? mode_lat_new : mode_lat_cur;
    end
end

// ==========================================================
// register read, data in the cycle after the strobe
always @(posedge sys_clk or posedge rst)
begin
    if (rst)
        reg_rdata_ff <= 32'h0000_0000;
    else if (reg_rd)
    begin
        case (reg_addr)
            `SRSEQ_REG_CTL:
                reg_rdata_ff <= {26'h0, 2'h0, dhrstsei_ff, halt_ctl_ff, 2'h0};
            `SRSEQ_REG_STS:
                reg_rdata_ff <= {22'h0, slave_bus_addr_ff, master_bus_slow_ff,
                                 halt_sts_ff, 1'b0, op_mode_ff};
            `SRSEQ_REG_MBSTS:
                reg_rdata_ff <= {24'h0, mb_errc_ff, 2'h0, mb_err_ff, mb_done_ff};
            `SRSEQ_REG_RST:
                reg_rdata_ff <= {23'h0, state_ff};
            `SRSEQ_REG_STICKY:
                reg_rdata_ff <= sticky_ff;
            default:
                reg_rdata_ff <= 32'h0000_0000;
        endcase
    end
    else
        reg_rdata_ff <= 32'h0000_0000;
end

endmodule

// file: bench/srseq_checker.sv
`timescale 1ns/1ns
`include "srseq_defs.vh"
module srseq_checker
#(
    parameter NPORT = 5
)
(
    // clock and reset
    input wire                     sys_clk,
    input wire                     rst,
    // register port
    input wire [`SRSEQ_ADDR_W-1:0] reg_addr,
    input wire [31:0]              reg_wdata,
    input wire                     reg_wr,
    input wire                     reg_rd,
    input wire [31:0]              reg_rdata_ff,
    // handshakes
    input wire                     pll_lock,
    input wire                     eep_wr,
    // sequencer outputs
    input wire                     pll_rst_ff,
    input wire                     train_en_ff,
    input wire                     stack_rst_ff,
    input wire                     quasi_rst_ff,
    input wire                     slave_bus_rst_ff,
    input wire                     master_bus_rst_ff,
    input wire                     eep_start_ff,
    input wire                     core_rst_ff,
    input wire [NPORT-1:0]         retrain_ff,
    input wire [2:0]               op_mode_ff,
    input wire                     low_latency_ff
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // sequencing
    chk_train_after_lock: assert property ($rose(train_en_ff) |-> !pll_rst_ff && $past(pll_lock))
        else $error("training started before pll lock");
    chk_slave_after_pll: assert property ($fell(slave_bus_rst_ff) |-> !pll_rst_ff)
        else $error("slave bus released before pll");
    chk_master_after_slave: assert property ($fell(master_bus_rst_ff) |-> !slave_bus_rst_ff)
        else $error("master bus released before slave bus");
    chk_core_after_buses: assert property ($fell(core_rst_ff) |-> !master_bus_rst_ff && !slave_bus_rst_ff)
        else $error("core released before buses");
    chk_quasi_stack_free: assert property (quasi_rst_ff |-> !stack_rst_ff)
        else $error("quasi state with stack reset held");
    chk_soft_reset_start: assert property (reg_wr && reg_addr == `SRSEQ_REG_CTL && reg_wdata[`SRSEQ_CTL_SOFT_FUNDAMENTAL_RESET_BIT] |-> ##[1:3] pll_rst_ff)
        else $error("soft reset did not restart sequence");
    // ==========================================================
    // mode decode and loader
    chk_load_mode: assert property (eep_start_ff |-> op_mode_ff == `SRSEQ_MODE_EEP || op_mode_ff == `SRSEQ_MODE_EEPLAT)
        else $error("eeprom load in a mode without load");
    chk_low_lat_mode: assert property (low_latency_ff |-> op_mode_ff == `SRSEQ_MODE_EEPLAT || op_mode_ff == `SRSEQ_MODE_LAT)
        else $error("low latency in wrong mode");
    chk_retrain_cause: assert property ((|retrain_ff) |-> $past(eep_wr) || $past(reg_wr))
        else $error("retrain without a write");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_ff == 32'h0)
        else $error("read data outside read slot");
    cov_load: cover property (eep_start_ff);
    cov_retrain: cover property (|retrain_ff);
    cov_run: cover property ($fell(core_rst_ff));
endmodule
bind srseq_top srseq_checker #(.NPORT(NPORT)) u_chk (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff), .pll_lock(pll_lock), .eep_wr(eep_wr),
    .pll_rst_ff(pll_rst_ff), .train_en_ff(train_en_ff), .stack_rst_ff(stack_rst_ff),
    .quasi_rst_ff(quasi_rst_ff), .slave_bus_rst_ff(slave_bus_rst_ff),
    .master_bus_rst_ff(master_bus_rst_ff), .eep_start_ff(eep_start_ff),
    .core_rst_ff(core_rst_ff), .retrain_ff(retrain_ff), .op_mode_ff(op_mode_ff),
    .low_latency_ff(low_latency_ff));

// file: bench/srseq_far_model.sv
`timescale 1ns/1ns
module srseq_far_model
(
    // clock and reset
    input  wire        sys_clk,
    input  wire        rst,
    // resets from the sequencer
    input  wire        pll_rst_ff,
    input  wire        slave_bus_rst_ff,
    input  wire        master_bus_rst_ff,
    input  wire        eep_start_ff,
    input  wire        load_err,
    // answers
    output logic       pll_lock,
    output logic       slave_bus_ready,
    output logic       master_bus_ready,
    output logic       eep_wr,
    output logic [3:0] eep_addr,
    output logic [31:0] eep_wdata,
    output logic       eep_done,
    output logic       eep_err,
    output logic [3:0] eep_err_code
);
    logic [3:0] cnt_ff;
    // ==========================================================
    // pll, buses and a short eeprom image
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            {pll_lock, slave_bus_ready, master_bus_ready} <= 3'h0;
            {eep_wr, eep_done, eep_err} <= 3'h0;
            {eep_addr, eep_err_code, eep_wdata, cnt_ff} <= 44'h0;
        end
        else
        begin
            pll_lock <= !pll_rst_ff;
            slave_bus_ready <= !slave_bus_rst_ff;
            master_bus_ready <= !master_bus_rst_ff;
            {eep_wr, eep_done, eep_err} <= 3'h0;
            // idle lines toggle so a stale value is never mistaken for data
            eep_addr <= ~eep_addr;
            eep_wdata <= ~eep_wdata;
            eep_err_code <= ~eep_err_code;
            cnt_ff <= eep_start_ff ? 4'h1 : (cnt_ff != 4'h0 ? cnt_ff + 4'h1 : 4'h0);
            if (cnt_ff == 4'h4)
            begin
                eep_wr <= !load_err;
                eep_addr <= 4'h3;
                eep_wdata <= 32'h0000_0004;
            end
            if (cnt_ff == 4'h8)
            begin
                // image far below the load time budget
                eep_done <= !load_err;
                eep_err <= load_err;
                eep_err_code <= 4'h9;
                cnt_ff <= 4'h0;
            end
        end
    end
endmodule

// file: bench/tb_top.sv
`timescale 1ns/1ns
`include "srseq_defs.vh"
module tb_top;
    logic sys_clk = 0, rst = 1, pin_n = 0, halt_strap = 0, slow_strap = 1, load_err = 0;
    logic [2:0] mode_straps = 3'h1;
    logic [3:0] addr_straps = 4'hA, reg_addr = 4'h0, eep_addr, eep_err_code;
    logic [31:0] reg_wdata = 32'h0, reg_rdata_ff, eep_wdata, rd_val;
    logic reg_wr = 0, reg_rd = 0, pll_lock, slave_bus_ready, master_bus_ready;
    logic eep_wr, eep_done, eep_err, pll_rst_ff, slave_bus_rst_ff, master_bus_rst_ff;
    logic eep_start_ff, core_rst_ff, us_hot_rst_ff, master_bus_slow_ff, low_latency_ff;
    logic train_late_ff, retry_late_ff, seen_us = 0;
    logic [3:0] slave_bus_addr_ff;
    logic [2:0] op_mode_ff;
    logic [4:0] ds_hot_rst_ff, retrain_ff, seen_rt = 5'h0, seen_ds = 5'h0;
    int n_mismatch = 0, checked = 0;
    always #2 sys_clk = ~sys_clk;
    // ==========================================================
    // design and far side
    srseq_top #(.NPORT(5), .TRAIN_CYC(50), .RETRY_CYC(200)) DUT (.sys_clk(sys_clk), .rst(rst),
        .fundamental_reset_pin_n(pin_n), .switch_op_mode_straps(mode_straps),
        .reset_halt(halt_strap), .master_mgmt_bus_slow_strap(slow_strap),
        .slave_mgmt_bus_addr_straps(addr_straps), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .hot_reset_req(1'b0),
        .pll_lock(pll_lock), .slave_bus_ready(slave_bus_ready),
        .master_bus_ready(master_bus_ready), .eep_wr(eep_wr), .eep_addr(eep_addr),
        .eep_wdata(eep_wdata), .eep_done(eep_done), .eep_err(eep_err),
        .eep_err_code(eep_err_code), .pll_rst_ff(pll_rst_ff), .train_en_ff(),
        .stack_rst_ff(), .quasi_rst_ff(), .slave_bus_rst_ff(slave_bus_rst_ff),
        .master_bus_rst_ff(master_bus_rst_ff), .master_bus_slow_ff(master_bus_slow_ff),
        .slave_bus_addr_ff(slave_bus_addr_ff), .eep_start_ff(eep_start_ff),
        .core_rst_ff(core_rst_ff), .us_hot_rst_ff(us_hot_rst_ff), .ds_hot_rst_ff(ds_hot_rst_ff),
        .retrain_ff(retrain_ff), .op_mode_ff(op_mode_ff), .low_latency_ff(low_latency_ff),
        .train_late_ff(train_late_ff), .retry_late_ff(retry_late_ff));
    srseq_far_model u_far (.sys_clk(sys_clk), .rst(rst), .pll_rst_ff(pll_rst_ff),
        .slave_bus_rst_ff(slave_bus_rst_ff), .master_bus_rst_ff(master_bus_rst_ff),
        .eep_start_ff(eep_start_ff), .load_err(load_err), .pll_lock(pll_lock),
        .slave_bus_ready(slave_bus_ready), .master_bus_ready(master_bus_ready),
        .eep_wr(eep_wr), .eep_addr(eep_addr), .eep_wdata(eep_wdata), .eep_done(eep_done),
        .eep_err(eep_err), .eep_err_code(eep_err_code));
    // pulses are caught here since they stand one cycle only
    always @(posedge sys_clk)
    begin
        if (|retrain_ff) seen_rt <= retrain_ff;
        if (|ds_hot_rst_ff) seen_ds <= ds_hot_rst_ff;
        if (us_hot_rst_ff) seen_us <= 1'b1;
    end
    // ==========================================================
    // helpers
    task tally_and_finish;
        if (n_mismatch == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (exp !== got)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge sys_clk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata_ff;
    endtask
    task wait_core(input logic v);
        int i;
        for (i = 0; i < 3000 && core_rst_ff !== v; i++) @(posedge sys_clk);
        #1;
        if (core_rst_ff !== v)
        begin
            check("core_rst wait", v, core_rst_ff);
            tally_and_finish;
        end
    endtask
    // ==========================================================
    // scenarios
    task t_bringup;
        wait_core(1'b0);
        check("op_mode", 3'h1, op_mode_ff);
        check("slow bus", 1'b1, master_bus_slow_ff);
        check("slave addr", 4'hA, slave_bus_addr_ff);
        check("retrain", 5'h04, seen_rt);
        check("late flags", 2'h0, {train_late_ff, retry_late_ff});
        rd(`SRSEQ_REG_STS); check("status", 32'h0000_02A1, rd_val);
        rd(`SRSEQ_REG_MBSTS); check("mb done", 32'h0000_0001, rd_val);
        rd(4'hF); check("unmapped", 32'h0, rd_val);
    endtask
    task t_soft_reset;
        @(posedge sys_clk);
        mode_straps <= 3'h0; slow_strap <= 1'b0; addr_straps <= 4'h0;
        wr(`SRSEQ_REG_CTL, 32'h1);
        wait_core(1'b1);
        wait_core(1'b0);
        check("kept mode", 3'h1, op_mode_ff);
        check("kept slow", 1'b1, master_bus_slow_ff);
    endtask
    task t_pin_halt_err;
        int i;
        @(posedge sys_clk);
        mode_straps <= 3'h3; halt_strap <= 1'b1; load_err <= 1'b1;
        pin_n <= 1'b0;
        wait_core(1'b1);
        repeat (4) @(posedge sys_clk);
        pin_n <= 1'b1;
        rd_val = 32'h0;
        for (i = 0; i < 200 && rd_val[0] !== 1'b1; i++) rd(`SRSEQ_REG_MBSTS);
        check("mb err", 32'h0000_0093, rd_val);
        if (rd_val[0] !== 1'b1) tally_and_finish;
        check("mode 3", 4'hB, {low_latency_ff, op_mode_ff});
        rd(`SRSEQ_REG_CTL); check("ctl halt", 32'h4, rd_val & 32'h4);
        rd(`SRSEQ_REG_STS); check("halt strap", 32'h10, rd_val & 32'h10);
        repeat (30) @(posedge sys_clk);
        load_err <= 1'b0;
        #1 check("held", 1'b1, core_rst_ff);
        wr(`SRSEQ_REG_CTL, 32'h0);
        wait_core(1'b0);
    endtask
    task t_hot_sticky;
        wr(`SRSEQ_REG_STICKY, 32'hA5A5_5A5A);
        wr(`SRSEQ_REG_CTL, 32'h2);
        wait_core(1'b1);
        wait_core(1'b0);
        check("pll kept", 1'b0, pll_rst_ff);
        rd(`SRSEQ_REG_STICKY); check("sticky", 32'hA5A5_5A5A, rd_val);
        wr(`SRSEQ_REG_CTL, 32'h10);
        wr(`SRSEQ_REG_CTL, 32'h220);
        repeat (4) @(posedge sys_clk);
        check("us bus rst", 1'b1, seen_us);
        check("ds bus rst", 5'h02, seen_ds);
    endtask
    task t_pin_no_load;
        @(posedge sys_clk);
        mode_straps <= 3'h2;
        halt_strap <= 1'b0;
        pin_n <= 1'b0;
        wait_core(1'b1);
        repeat (4) @(posedge sys_clk);
        pin_n <= 1'b1;
        wait_core(1'b0);
        check("mode 2", 4'hA, {low_latency_ff, op_mode_ff});
        check("fast bus", 1'b0, master_bus_slow_ff);
        check("addr 0", 4'h0, slave_bus_addr_ff);
        rd(`SRSEQ_REG_MBSTS);
        check("no load", 32'h0, rd_val);
    endtask
    initial
    begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        pin_n <= 1'b1;
        t_bringup;
        t_soft_reset;
        t_pin_halt_err;
        t_hot_sticky;
        t_pin_no_load;
        tally_and_finish;
    end
endmodule
